//--- src/dhi_pkg.sv
// Purpose: shared constants for the display host interface
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   link pins sampled synchronously on both ends
package dhi_pkg;
  localparam logic [1:0] DHI_SEL_I2C   = 2'b01; // {select_1, select_0}
  localparam logic [1:0] DHI_SEL_SPI   = 2'b00;
  localparam logic [1:0] DHI_SEL_P68   = 2'b10;
  localparam logic [1:0] DHI_SEL_P80   = 2'b11;
  localparam int         DHI_CLK_MHZ   = 10;
  localparam int         DHI_CYC_NS    = 300;
  localparam int         DHI_HALF_CYC  = (DHI_CYC_NS * DHI_CLK_MHZ + 1999) / 2000;
  localparam logic [6:0] DHI_I2C_ADDR_HI = 7'h3c; // arbitrary base address
  localparam logic [7:0] DHI_READ_IDLE = 8'h00;
endpackage : dhi_pkg

//--- src/dhi_link_if.sv
// Purpose: pin bundle between host and display ends
// Assumes: shared sys_clk domain
// Notes:   bus level resolved from enables here
`timescale 1ns/1ps
interface dhi_link_if;
  logic       cs_n;
  logic       dc;
  logic       rw_wr;
  logic       en_rd;
  logic [7:0] host_do;
  logic [7:0] host_oe;
  logic [7:0] dev_do;
  logic [7:0] dev_oe;
  logic [7:0] bus;
  // wired-and for i2c style, driven value otherwise
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (host_oe[i] && dev_oe[i]) bus[i] = host_do[i] & dev_do[i];
      else if (host_oe[i]) bus[i] = host_do[i];
      else if (dev_oe[i]) bus[i] = dev_do[i];
      // released i2c lines float high, unused pins sit at ground
      else if (i < 3) bus[i] = 1'b1;
      else bus[i] = 1'b0;
    end
  end
  modport dev  (input cs_n, dc, rw_wr, en_rd, bus, output dev_do, dev_oe);
  modport host (output cs_n, dc, rw_wr, en_rd, host_do, host_oe, input bus);
endinterface : dhi_link_if

//--- src/dhi_device.sv
// Purpose: display-side end of the host link, four selectable modes
// Assumes: select pins static; link pins synchronous to sys_clk
// Notes:   bytes delivered as one-cycle strobes with data/command flag
`timescale 1ns/1ps
module dhi_device
  import dhi_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       reset_n_i,
  input  wire logic       interface_select_0_i,
  input  wire logic       interface_select_1_i,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_stb_o,
  output logic            wr_is_data_o,
  output logic [7:0]      wr_byte_o,
  output logic            rd_stb_o,
  output logic            init_o,
  dhi_link_if.dev         link
);
  logic [1:0] sel;
  logic       rst_all;
  logic       sel_n;
  logic       en_ff, wr_ff, rd_ff, scl_ff, sda_ff;
  logic       acc68, wr80, rd80;
  logic [7:0] shift_ff;
  logic [2:0] bit_ff;
  logic       wr_stb_ff, wr_dc_ff, rd_stb_ff, init_ff;
  logic [7:0] wr_byte_ff, dev_do_ff, dev_oe_ff;
  // i2c receive state
  logic       i2c_act_ff, i2c_addr_ff, i2c_ack_ff, i2c_ctrl_ff, i2c_dc_ff, i2c_skip_ff;
  logic [3:0] i2c_cnt_ff;

  assign sel = {interface_select_1_i, interface_select_0_i};
  assign rst_all = rst_i | ~reset_n_i;
  assign sel_n = link.cs_n;

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      en_ff  <= 1'b0;
      wr_ff  <= 1'b1;
      rd_ff  <= 1'b1;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      en_ff  <= link.en_rd;
      wr_ff  <= link.rw_wr;
      rd_ff  <= link.en_rd;
      scl_ff <= link.bus[0];
      sda_ff <= link.bus[1];
    end
  end

  // 68 enable falling edge completes the access
  assign acc68 = (sel == DHI_SEL_P68) && !sel_n && en_ff && !link.en_rd;
  // write latched at write strobe rising edge
  assign wr80  = (sel == DHI_SEL_P80) && !sel_n && !wr_ff && link.rw_wr;
  // read counted at read strobe fall
  assign rd80  = (sel == DHI_SEL_P80) && !sel_n && rd_ff && !link.en_rd;

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      shift_ff    <= 8'h00;
      bit_ff      <= 3'h0;
      wr_stb_ff   <= 1'b0;
      wr_dc_ff    <= 1'b0;
      wr_byte_ff  <= 8'h00;
      rd_stb_ff   <= 1'b0;
      i2c_act_ff  <= 1'b0;
      i2c_addr_ff <= 1'b0;
      i2c_ctrl_ff <= 1'b0;
      i2c_dc_ff   <= 1'b0;
      i2c_skip_ff <= 1'b0;
      i2c_cnt_ff  <= 4'h0;
    end else begin
      wr_stb_ff <= 1'b0;
      rd_stb_ff <= 1'b0;
      case (sel)
        DHI_SEL_P68, DHI_SEL_P80: begin
          if ((acc68 && !link.rw_wr) || wr80) begin
            wr_stb_ff  <= 1'b1;
            wr_dc_ff   <= link.dc;
            wr_byte_ff <= link.bus;
          end
          if ((acc68 && link.rw_wr) || rd80) rd_stb_ff <= 1'b1;
        end
        DHI_SEL_SPI: begin
          if (sel_n) begin
            bit_ff <= 3'h0;
          end else if (!scl_ff && link.bus[0]) begin
            shift_ff <= {shift_ff[6:0], link.bus[1]};
            bit_ff   <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              wr_stb_ff  <= 1'b1;
              wr_dc_ff   <= link.dc;
              wr_byte_ff <= {shift_ff[6:0], link.bus[1]};
            end
          end
        end
        default: begin
          // start: data falls while clock high
          if (!sel_n && scl_ff && link.bus[0] && sda_ff && !link.bus[1]) begin
            i2c_act_ff  <= 1'b1;
            i2c_addr_ff <= 1'b1;
            i2c_ctrl_ff <= 1'b1;
            i2c_skip_ff <= 1'b0;
            i2c_cnt_ff  <= 4'h0;
          end else if (scl_ff && link.bus[0] && !sda_ff && link.bus[1]) begin
            i2c_act_ff <= 1'b0;
          end else if (i2c_act_ff && !scl_ff && link.bus[0]) begin
            if (i2c_cnt_ff == 4'h8) begin
              i2c_cnt_ff <= 4'h0;
            end else begin
              shift_ff   <= {shift_ff[6:0], link.bus[1]};
              i2c_cnt_ff <= i2c_cnt_ff + 4'h1;
            end
          end else if (i2c_act_ff && scl_ff && !link.bus[0]) begin
            if (i2c_cnt_ff == 4'h8) begin
              if (i2c_addr_ff) begin
                i2c_addr_ff <= 1'b0;
                i2c_skip_ff <= shift_ff[7:1] != {DHI_I2C_ADDR_HI[6:1], link.dc};
              end else if (i2c_ctrl_ff && !i2c_skip_ff) begin
                // control byte: bit6 picks data or command
                i2c_dc_ff   <= shift_ff[6];
                i2c_ctrl_ff <= ~shift_ff[7];
              end else if (!i2c_skip_ff) begin
                wr_stb_ff   <= 1'b1;
                wr_dc_ff    <= i2c_dc_ff;
                wr_byte_ff  <= shift_ff;
                i2c_ctrl_ff <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // ack drives bit 2 low during the ninth clock
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      i2c_ack_ff <= 1'b0;
    end else begin
      i2c_ack_ff <= (sel == DHI_SEL_I2C) && i2c_act_ff && !i2c_skip_ff
                    && (i2c_cnt_ff == 4'h8) && !i2c_addr_ff;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      dev_do_ff <= 8'h00;
      dev_oe_ff <= 8'h00;
    end else if (sel == DHI_SEL_I2C) begin
      dev_do_ff <= 8'h00;
      dev_oe_ff <= {5'h00, i2c_ack_ff | ((i2c_cnt_ff == 4'h8) && i2c_act_ff
                   && !i2c_skip_ff && !scl_ff), 2'b00};
    end else if (!sel_n && (((sel == DHI_SEL_P68) && link.rw_wr && link.en_rd)
                 || ((sel == DHI_SEL_P80) && !link.en_rd))) begin
      dev_do_ff <= rd_data_i;
      dev_oe_ff <= 8'hff;
    end else begin
      dev_do_ff <= DHI_READ_IDLE;
      dev_oe_ff <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) init_ff <= 1'b1;
    else init_ff <= ~reset_n_i;
  end

  assign wr_stb_o     = wr_stb_ff;
  assign wr_is_data_o = wr_dc_ff;
  assign wr_byte_o    = wr_byte_ff;
  assign rd_stb_o     = rd_stb_ff;
  assign init_o       = init_ff;
  assign link.dev_do  = dev_do_ff;
  assign link.dev_oe  = dev_oe_ff;
endmodule : dhi_device

//--- src/dhi_host.sv
// Purpose: host-side driver of the display link, parallel and serial
// Assumes: select pins static, same values as the device sees
// Notes:   i2c mode not generated here; host only idles its pins
`timescale 1ns/1ps
module dhi_host
  import dhi_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       interface_select_0_i,
  input  wire logic       interface_select_1_i,
  input  wire logic       req_i,
  input  wire logic       req_read_i,
  input  wire logic       req_is_data_i,
  input  wire logic [7:0] req_byte_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rd_byte_o,
  output logic            reset_n_o,
  dhi_link_if.host        link
);
  typedef enum logic [2:0] {
    DHI_IDLE = 3'b001,
    DHI_ACT  = 3'b010,
    DHI_END  = 3'b100
  } dhi_st_e;
  dhi_st_e    st_ff;
  logic [1:0] sel;
  logic [7:0] cnt_ff, byte_ff, rd_ff, do_ff, oe_ff;
  logic [3:0] bit_ff;
  logic       rd_req_ff, dc_ff, cs_n_ff, rw_ff, en_ff, busy_ff, done_ff, rst_n_ff;

  assign sel = {interface_select_1_i, interface_select_0_i};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) rst_n_ff <= 1'b0;
    else rst_n_ff <= 1'b1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_ff     <= DHI_IDLE;
      cnt_ff    <= 8'h00;
      bit_ff    <= 4'h0;
      byte_ff   <= 8'h00;
      rd_ff     <= 8'h00;
      rd_req_ff <= 1'b0;
      dc_ff     <= 1'b0;
      cs_n_ff   <= 1'b1;
      rw_ff     <= 1'b0;
      en_ff     <= 1'b0;
      do_ff     <= 8'h00;
      oe_ff     <= 8'h00;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        DHI_IDLE: begin
          // idle levels per mode; rw, enable high only in 80 mode, low otherwise
          rw_ff <= (sel == DHI_SEL_P80);
          en_ff <= (sel == DHI_SEL_P80);
          oe_ff <= (sel == DHI_SEL_I2C) ? 8'h00 : 8'hff;
          do_ff <= 8'h00;
          if (req_i && sel != DHI_SEL_I2C) begin
            dc_ff     <= req_is_data_i;
            byte_ff   <= req_byte_i;
            rd_req_ff <= req_read_i;
            busy_ff   <= 1'b1;
            cs_n_ff   <= 1'b0;
            cnt_ff    <= 8'h00;
            bit_ff    <= 4'h0;
            st_ff     <= DHI_ACT;
            if (sel == DHI_SEL_P68) rw_ff <= req_read_i;
            if (sel == DHI_SEL_SPI) do_ff <= 8'h00;
            else begin
              do_ff <= req_byte_i;
              oe_ff <= req_read_i ? 8'h00 : 8'hff;
            end
          end
        end
        DHI_ACT: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (sel == DHI_SEL_SPI) begin
            if (cnt_ff == 8'(DHI_HALF_CYC - 1)) begin
              cnt_ff <= 8'h00;
              if (!do_ff[0]) begin
                do_ff <= {6'h00, byte_ff[7], 1'b1};
              end else begin
                do_ff <= {6'h00, byte_ff[6], 1'b0};
                byte_ff <= {byte_ff[6:0], 1'b0};
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'h7) st_ff <= DHI_END;
              end
            end else if (!do_ff[0] && cnt_ff == 8'h00 && bit_ff == 4'h0) begin
              do_ff <= {6'h00, byte_ff[7], 1'b0};
            end
          end else begin
            // strobe low (80) or enable high (68) for one half cycle
            // 80 write keeps the read strobe high, else the device drives the bus
            if (cnt_ff == 8'h00) en_ff <= (sel == DHI_SEL_P68) | ~rd_req_ff;
            if (cnt_ff == 8'h00 && sel == DHI_SEL_P80 && !rd_req_ff) rw_ff <= 1'b0;
            if (cnt_ff == 8'(DHI_HALF_CYC)) begin
              if (rd_req_ff) rd_ff <= link.bus;
              en_ff <= (sel == DHI_SEL_P80);
              if (sel == DHI_SEL_P80) rw_ff <= 1'b1;
              st_ff <= DHI_END;
            end
          end
        end
        DHI_END: begin
          cs_n_ff <= 1'b1;
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          oe_ff   <= (sel == DHI_SEL_I2C) ? 8'h00 : 8'hff;
          do_ff   <= 8'h00;
          st_ff <= DHI_IDLE;
        end
        default: st_ff <= DHI_IDLE;
      endcase
    end
  end

  assign busy_o       = busy_ff;
  assign done_o       = done_ff;
  assign rd_byte_o    = rd_ff;
  assign reset_n_o    = rst_n_ff;
  assign link.cs_n    = cs_n_ff;
  assign link.dc      = dc_ff;
  assign link.rw_wr   = rw_ff;
  assign link.en_rd   = en_ff;
  assign link.host_do = do_ff;
  assign link.host_oe = oe_ff;
endmodule : dhi_host

//--- dv/dhi_link_asserts.sv
// Purpose: link checks between host and display ends
// Assumes: one clock, sync reset high, static select pins
// Notes:   device read answer allowed a 1..3 cycle lag
`timescale 1ns/1ps
module dhi_link_asserts
  import dhi_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       interface_select_0_i,
  input wire logic       interface_select_1_i,
  input wire logic       cs_n,
  input wire logic       rw_wr,
  input wire logic       en_rd,
  input wire logic [7:0] dev_oe,
  input wire logic [7:0] bus
);
  logic [1:0] md;
  assign md = {interface_select_1_i, interface_select_0_i};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd80; md == DHI_SEL_P80 && !cs_n && $fell(en_rd); endsequence
  sequence s_rd68; md == DHI_SEL_P68 && !cs_n && rw_wr && $rose(en_rd); endsequence
  property p_sel_idle; cs_n && $past(cs_n) |-> dev_oe == 8'h00; endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("idle drive");
  property p_oe_width;
    |dev_oe |-> (md[1] && dev_oe == 8'hff) || (md == DHI_SEL_I2C && dev_oe == 8'h04);
  endproperty
  a_oe_width: assert property (p_oe_width) else $error("bus width");
  property p_oe_read; |dev_oe |-> !cs_n || !$past(cs_n); endproperty
  a_oe_read: assert property (p_oe_read) else $error("late release");
  property p_rd80; s_rd80 |-> ##[1:3] dev_oe == 8'hff; endproperty
  a_rd80: assert property (p_rd80) else $error("no read drive");
  property p_rd68; s_rd68 |-> ##[1:3] dev_oe == 8'hff; endproperty
  a_rd68: assert property (p_rd68) else $error("no enable read");
  property p_wr80; md == DHI_SEL_P80 && !cs_n && !rw_wr |-> dev_oe == 8'h00; endproperty
  a_wr80: assert property (p_wr80) else $error("drive in write");
  property p_wr68;
    md == DHI_SEL_P68 && !cs_n && !rw_wr && !$past(rw_wr) |-> dev_oe == 8'h00;
  endproperty
  a_wr68: assert property (p_wr68) else $error("drive in write");
  property p_ser_tie; !md[1] |-> !rw_wr && !en_rd; endproperty
  a_ser_tie: assert property (p_ser_tie) else $error("pins not low");
  property p_spi_unused; md == DHI_SEL_SPI |-> bus[7:3] == 5'h00; endproperty
  a_spi_unused: assert property (p_spi_unused) else $error("unused pins");
endmodule : dhi_link_asserts

//--- dv/tb.sv
// Purpose: end-to-end bench for host and display ends
// Assumes: 10 MHz clock, sync reset high
// Notes:   i2c end only idles, the host does not generate it
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb
  import dhi_pkg::*;
;
  logic       sys_clk_i, rst_i, sel0, sel1, req_i, req_rd, req_dc;
  logic [7:0] req_b, rd_data, rd_byte, wr_byte, got_b;
  logic       busy, done, init, rst_n, wr_stb, wr_dc, rd_stb, got_dc;
  int         mismatches, tests_run, cycles, wr_cnt, rd_cnt;
  dhi_link_if lnk ();
  dhi_host u_dhi_host (.sys_clk_i, .rst_i, .interface_select_0_i(sel0),
    .interface_select_1_i(sel1), .req_i, .req_read_i(req_rd), .req_is_data_i(req_dc),
    .req_byte_i(req_b), .busy_o(busy), .done_o(done), .rd_byte_o(rd_byte),
    .reset_n_o(rst_n), .link(lnk.host));
  dhi_device u_dhi_device (.sys_clk_i, .rst_i, .reset_n_i(rst_n),
    .interface_select_0_i(sel0), .interface_select_1_i(sel1), .rd_data_i(rd_data),
    .wr_stb_o(wr_stb), .wr_is_data_o(wr_dc), .wr_byte_o(wr_byte), .rd_stb_o(rd_stb),
    .init_o(init), .link(lnk.dev));
  dhi_link_asserts u_dhi_link_asserts (.sys_clk_i, .rst_i, .interface_select_0_i(sel0),
    .interface_select_1_i(sel1), .cs_n(lnk.cs_n), .rw_wr(lnk.rw_wr),
    .en_rd(lnk.en_rd), .dev_oe(lnk.dev_oe), .bus(lnk.bus));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // strobes are one cycle wide, so latch what they carry
  always @(posedge sys_clk_i) begin
    if (wr_stb === 1'b1) begin
      wr_cnt++;
      got_b = wr_byte;
      got_dc = wr_dc;
    end
    if (rd_stb === 1'b1) rd_cnt++;
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic do_reset(input logic [1:0] md);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    {sel1, sel0} <= md;
    repeat (2) @(posedge sys_clk_i);
    #1 `CHK(init, 1'b1)
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1 `CHK(init, 1'b0)
  endtask : do_reset
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] b);
    int n;
    @(posedge sys_clk_i);
    req_i <= 1'b1;
    req_rd <= rd;
    req_dc <= dc;
    req_b <= b;
    @(posedge sys_clk_i);
    req_i <= 1'b0;
    #1 `CHK(busy, 1'b1)
    `CHK(lnk.dc, dc)
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1 n++;
    end while (done !== 1'b1 && n < 300);
    `CHK(busy, 1'b0)
    `CHK(lnk.dc, dc)
    if (n >= 300) begin
      mismatches++;
      $display("ERROR %0t: no completion", $time);
    end
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask : xfer
  task automatic t_parallel(input logic [1:0] md);
    int n, r;
    do_reset(md);
    n = wr_cnt;
    r = rd_cnt;
    xfer(1'b0, 1'b0, 8'ha5);
    `CHK(got_dc, 1'b0)
    `CHK(got_b, 8'ha5)
    xfer(1'b0, 1'b1, 8'h5a);
    `CHK(got_dc, 1'b1)
    `CHK(got_b, 8'h5a)
    rd_data <= 8'hc3;
    xfer(1'b1, 1'b1, 8'h00);
    `CHK(rd_byte, 8'hc3)
    `CHK(rd_cnt, r + 1)
    `CHK(wr_cnt, n + 2)
    `CHK(lnk.dev_oe, 8'h00)
  endtask : t_parallel
  task automatic t_spi();
    int n;
    do_reset(DHI_SEL_SPI);
    n = wr_cnt;
    xfer(1'b0, 1'b0, 8'h81);
    `CHK(got_b, 8'h81)
    `CHK(got_dc, 1'b0)
    xfer(1'b0, 1'b1, 8'h7e);
    `CHK(got_b, 8'h7e)
    `CHK(got_dc, 1'b1)
    `CHK(wr_cnt, n + 2)
  endtask : t_spi
  task automatic t_i2c();
    int n;
    do_reset(DHI_SEL_I2C);
    n = wr_cnt;
    repeat (50) @(posedge sys_clk_i);
    #1 `CHK(wr_cnt, n)
    `CHK(lnk.dev_oe, 8'h00)
  endtask : t_i2c
  initial begin
    rst_i = 1'b1;
    {sel1, sel0} = DHI_SEL_P68;
    {req_i, req_rd, req_dc} = 3'h0;
    req_b = 8'h00;
    rd_data = 8'h00;
    t_parallel(DHI_SEL_P68);
    t_parallel(DHI_SEL_P80);
    t_spi();
    t_i2c();
    summarize();
  end
endmodule : tb
